// ### chop_cfg_pkg.sv
// package: register map, field layout and resets of the chop and channel 0 slice
package chop_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // printed register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CHOP_CFG  = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_RSVD_07   = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_RSVD_08   = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_INPUT_CFG = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_OCAL_HIGH = 4'hA;
  localparam logic [ADDR_W-1:0] IDX_OCAL_LOW  = 4'hB;
  localparam logic [ADDR_W-1:0] IDX_STATUS    = 4'hC;

  // field positions
  localparam int CHOP_DLY_LSB = 9;
  localparam int CHOP_DLY_W   = 4;
  localparam int CHOP_EN_BIT  = 8;
  localparam int MUX_LSB      = 0;
  localparam int MUX_W        = 2;
  localparam int OCAL_LOW_LSB = 8;

  // writable masks (read-only reserved bits read zero)
  localparam logic [REG_W-1:0] MASK_RW      = 16'hFFFF;
  localparam logic [REG_W-1:0] MASK_RSVD_08 = 16'hFF0F;
  localparam logic [REG_W-1:0] MASK_INPUT_CFG = 16'hFFC7;
  localparam logic [REG_W-1:0] MASK_OCAL_LO = 16'hFF00;

  // reset values
  localparam logic [REG_W-1:0] RST_CHOP_CFG = 16'h0600;
  localparam logic [REG_W-1:0] RST_ZERO     = 16'h0000;

  // answer returned on unmapped read
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // input routing codes
  typedef enum logic [1:0] {
    MUX_PINS  = 2'h0,
    MUX_SHORT = 2'h1,
    MUX_TPOS  = 2'h2,
    MUX_TNEG  = 2'h3
  } mux_sel_t;

  localparam int DLY_CNT_W = 17;
endpackage

// ### chop_settle_timer.sv
// settle timer: counts modulator clock enables after a chop phase change
`timescale 1ns/1ns
module chop_settle_timer
  import chop_cfg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  modTick,
  input  wire logic                  start,
  input  wire logic [CHOP_DLY_W-1:0] delayCode,
  output logic                       settling,
  output logic                       settled
);
  logic [DLY_CNT_W-1:0] remaining;

  // code n gives 2^(n+1) modulator periods: 2 .. 65536
  function automatic logic [DLY_CNT_W-1:0] delay_periods(input logic [CHOP_DLY_W-1:0] code);
    delay_periods = DLY_CNT_W'(17'h1) << ({1'b0, code} + 5'h01);
  endfunction

  wire logic lastTick = settling && modTick && (remaining == DLY_CNT_W'(1));

  always_ff @(posedge clk) begin
    if (srst) begin
      remaining <= '0;
      settling  <= 1'b0;
      settled   <= 1'b0;
    end else if (start) begin
      remaining <= delay_periods(delayCode);
      settling  <= 1'b1;
      settled   <= 1'b0;
    end else begin
      settled <= lastTick;
      if (lastTick)
        settling <= 1'b0;
      if (settling && modTick)
        remaining <= remaining - DLY_CNT_W'(1);
    end
  end
endmodule

// ### chop_ch0_regs.sv
// register bank: global chop configuration and channel 0 input and offset
//
// Notes on behaviour
// - bits 12:9 pick settle delay 2^(code+1) modulator periods, reset 16
// - bit 8 turns chop mode on; off after reset
// - bits 1:0 route channel 0: pins, shorted, positive or negative test
// - high offset register holds offset bits 23:8
// - low offset register holds bits 7:0 in upper byte; lower byte reads zero
`timescale 1ns/1ns
module chop_ch0_regs
  import chop_cfg_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [ADDR_W+1:0]      address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [DATA_W-1:0]      writedata,
  input  wire logic [3:0]             byteenable,
  output logic [DATA_W-1:0]           readdata,
  output logic                        waitrequest,
  output logic [1:0]                  response,
  input  wire logic                   modTick,
  input  wire logic                   chopPhaseStart,
  output logic                        chop_mode_on,
  output logic [CHOP_DLY_W-1:0]       chop_settle_delay,
  output logic                        chopSettling,
  output logic                        chopSettled,
  output mux_sel_t                    ch_zero_input_select,
  output logic signed [23:0]          chZeroOffset
);
  import chop_cfg_pkg::*;

  logic [REG_W-1:0] chopCfg;
  logic [REG_W-1:0] rsvd07;
  logic [REG_W-1:0] rsvd08;
  logic [REG_W-1:0] ch0Cfg;
  logic [REG_W-1:0] ch_zero_offset_high_word;
  logic [REG_W-1:0] ocalLow;
  logic             served;
  logic             settlingNow;
  logic             settledNow;

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [REG_W-1:0] data,
                                             input logic [1:0]       be,
                                             input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lane) | (data & lane);
  endfunction

  // one wait cycle, then the request is served
  wire logic              req     = (read || write) && !served;
  wire logic [ADDR_W-1:0] idx     = address[ADDR_W+1:2];
  wire logic              alignOk = (address[1:0] == 2'h0);
  wire logic              hitChop = alignOk && (idx == IDX_CHOP_CFG);
  wire logic              hit07   = alignOk && (idx == IDX_RSVD_07);
  wire logic              hit08   = alignOk && (idx == IDX_RSVD_08);
  wire logic              hitCh0  = alignOk && (idx == IDX_INPUT_CFG);
  wire logic              hitHigh = alignOk && (idx == IDX_OCAL_HIGH);
  wire logic              hitLow  = alignOk && (idx == IDX_OCAL_LOW);
  wire logic              hitStat = alignOk && (idx == IDX_STATUS);
  wire logic              mapped  = hitChop | hit07 | hit08 | hitCh0 | hitHigh | hitLow
                                    | hitStat;
  wire logic              doWrite = req && write;
  wire logic [REG_W-1:0]  wdata   = writedata[REG_W-1:0];
  wire logic [1:0]        be      = byteenable[1:0];

  wire logic [REG_W-1:0] statusWord = {13'h0000, chop_mode_on, settledNow, settlingNow};

  wire logic [REG_W-1:0] readMux =
      hitChop ? chopCfg :
      hit07   ? rsvd07 :
      hit08   ? (rsvd08 & MASK_RSVD_08) :
      hitCh0  ? (ch0Cfg & MASK_INPUT_CFG) :
      hitHigh ? ch_zero_offset_high_word :
      hitLow  ? (ocalLow & MASK_OCAL_LO) :
      statusWord;

  wire logic [DATA_W-1:0] next_readdata = mapped ? {16'h0000, readMux} : UNMAPPED_READ;
  wire logic [1:0]        next_response = mapped ? 2'h0 : 2'h3;
  wire logic [7:0]        ch_zero_offset_low_byte = ocalLow[REG_W-1:OCAL_LOW_LSB];

  always_ff @(posedge clk) begin
    if (srst) begin
      served      <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= '0;
      response    <= 2'h0;
    end else begin
      served      <= req;
      waitrequest <= !req;
      if (req) begin
        readdata <= read ? next_readdata : '0;
        response <= next_response;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chopCfg                  <= RST_CHOP_CFG;
      rsvd07                   <= RST_ZERO;
      rsvd08                   <= RST_ZERO;
      ch0Cfg                   <= RST_ZERO;
      ch_zero_offset_high_word <= RST_ZERO;
      ocalLow                  <= RST_ZERO;
    end else if (doWrite) begin
      if (hitChop)
        chopCfg <= merge(chopCfg, wdata, be, MASK_RW);
      if (hit07)
        rsvd07 <= merge(rsvd07, wdata, be, MASK_RW);
      if (hit08)
        rsvd08 <= merge(rsvd08, wdata, be, MASK_RSVD_08);
      if (hitCh0)
        ch0Cfg <= merge(ch0Cfg, wdata, be, MASK_INPUT_CFG);
      if (hitHigh)
        ch_zero_offset_high_word <= merge(ch_zero_offset_high_word, wdata, be, MASK_RW);
      if (hitLow)
        ocalLow <= merge(ocalLow, wdata, be, MASK_OCAL_LO);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chop_mode_on         <= 1'b0;
      chop_settle_delay    <= RST_CHOP_CFG[CHOP_DLY_LSB +: CHOP_DLY_W];
      ch_zero_input_select <= MUX_PINS;
      chZeroOffset         <= '0;
      chopSettling         <= 1'b0;
      chopSettled          <= 1'b0;
    end else begin
      chop_mode_on         <= chopCfg[CHOP_EN_BIT];
      chop_settle_delay    <= chopCfg[CHOP_DLY_LSB +: CHOP_DLY_W];
      ch_zero_input_select <= mux_sel_t'(ch0Cfg[MUX_LSB +: MUX_W]);
      chZeroOffset         <= {ch_zero_offset_high_word, ch_zero_offset_low_byte};
      chopSettling         <= settlingNow;
      chopSettled          <= settledNow;
    end
  end

  chop_settle_timer settleTimer (
    .clk       (clk),
    .srst      (srst),
    .modTick   (modTick),
    .start     (chopPhaseStart && chop_mode_on),
    .delayCode (chop_settle_delay),
    .settling  (settlingNow),
    .settled   (settledNow)
  );
endmodule

// ### chop_ch0_regs_monitor.sv
// checker: port relations of the chop and channel 0 register bank
`timescale 1ns/1ns
module chop_ch0_regs_monitor
  import chop_cfg_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic [ADDR_W+1:0]     address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [DATA_W-1:0]     writedata,
  input wire logic [3:0]            byteenable,
  input wire logic [DATA_W-1:0]     readdata,
  input wire logic                  waitrequest,
  input wire logic [1:0]            response,
  input wire logic                  chop_mode_on,
  input wire logic [CHOP_DLY_W-1:0] chop_settle_delay,
  input wire logic                  chopSettled,
  input wire mux_sel_t              ch_zero_input_select,
  input wire logic signed [23:0]    chZeroOffset
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic wDone = write && !waitrequest;
  wire logic rDone = read && !waitrequest;
  rst_values_a: assert property ($fell(srst) |-> chop_settle_delay == 4'h3 && !chop_mode_on)
    else $error("reset value of chop fields wrong");
  dly_update_a: assert property (wDone && address == 6'h18 && byteenable[1] |=>
    chop_settle_delay == $past(writedata[12:9])) else $error("settle delay not updated");
  chop_on_a: assert property (wDone && address == 6'h18 && byteenable[1] |=>
    chop_mode_on == $past(writedata[8])) else $error("chop mode not updated");
  mux_update_a: assert property (wDone && address == 6'h24 && byteenable[0] |=>
    ch_zero_input_select == $past(writedata[1:0])) else $error("input select not updated");
  ocal_high_a: assert property (wDone && address == 6'h28 && byteenable[1:0] == 2'h3 |=>
    chZeroOffset[23:8] == $past(writedata[15:0])) else $error("offset high word wrong");
  ocal_low_a: assert property (wDone && address == 6'h2C && byteenable[1] |=>
    chZeroOffset[7:0] == $past(writedata[15:8])) else $error("offset low byte wrong");
  low_zero_a: assert property (rDone && address == 6'h2C |-> readdata[7:0] == 8'h00)
    else $error("offset low register lower byte not zero");
  settle_pulse_a: assert property (chopSettled |=> !chopSettled)
    else $error("settled pulse longer than one cycle");
  cover property (wDone && address == 6'h18);
  cover property (rDone && response == 2'h3);
  cover property (chopSettled);
endmodule
bind chop_ch0_regs chop_ch0_regs_monitor mon_u (.clk(clk), .srst(srst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .chop_mode_on(chop_mode_on), .chop_settle_delay(chop_settle_delay),
  .chopSettled(chopSettled), .ch_zero_input_select(ch_zero_input_select),
  .chZeroOffset(chZeroOffset));

// ### adc_chop_and_ch0_config_regs_tb_top.sv
// testbench: register bank reads, writes and field outputs
`timescale 1ns/1ns
module adc_chop_and_ch0_config_regs_tb_top;
  import chop_cfg_pkg::*;
  logic clk, srst, read, write, modTick, chopPhaseStart, chop_mode_on, chopSettling, chopSettled;
  logic waitrequest;
  logic [5:0] address;
  logic [31:0] writedata, readdata, seed, r;
  logic [3:0] byteenable, chop_settle_delay;
  logic [1:0] response;
  mux_sel_t ch_zero_input_select;
  logic signed [23:0] chZeroOffset;
  logic [33:0] q[$];
  logic [33:0] settleQ[$];
  int settleCycles = 0;
  int mismatches, n_checks, i;
  chop_ch0_regs dut_u (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .modTick(modTick),
    .chopPhaseStart(chopPhaseStart), .chop_mode_on(chop_mode_on),
    .chop_settle_delay(chop_settle_delay), .chopSettling(chopSettling),
    .chopSettled(chopSettled), .ch_zero_input_select(ch_zero_input_select),
    .chZeroOffset(chZeroOffset));
  always #2 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {16'h0000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] d, input logic [1:0] rs = 2'h0);
    q.push_back({rs, 16'h0000, d});
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (read && !waitrequest) chk("readback", {response, readdata}, q.pop_front());
  end
  always @(posedge clk) begin
    if (chopPhaseStart && chop_mode_on) settleCycles = 0;
    else settleCycles++;
    if (chopSettled) chk("settle cycles", 34'(settleCycles), settleQ.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    seed = 32'h37;
    clk = 0; srst = 1; read = 0; write = 0; address = 0; writedata = 0;
    byteenable = 4'hF; modTick = 0; chopPhaseStart = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (i = 6; i < 12; i++) rd(6'(i * 4), (i == 6) ? 16'h0600 : 16'h0000);
    // reserved fields of the chop register written as zero throughout
    for (i = 0; i < 16; i++) begin
      r = xs();
      bus(1'b1, 6'h18, {3'h0, i[3:0], r[0], 8'h00});
      chk("settle delay", 34'(chop_settle_delay), 34'(i[3:0]));
      chk("chop on", 34'(chop_mode_on), 34'(r[0]));
      rd(6'h18, {3'h0, i[3:0], r[0], 8'h00});
    end
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 6'h24, 16'(i));
      chk("input select", 34'(ch_zero_input_select), 34'(i[1:0]));
      rd(6'h24, 16'(i));
    end
    r = xs();
    bus(1'b1, 6'h28, r[15:0]);
    bus(1'b1, 6'h2C, r[31:16]);
    chk("offset", {10'h000, chZeroOffset}, 34'({r[15:0], r[31:24]}));
    rd(6'h28, r[15:0]);
    rd(6'h2C, {r[31:24], 8'h00});
    r = xs();
    bus(1'b1, 6'h18, {3'h0, 2'h0, r[1:0], 1'b1, 8'h00});
    settleQ.push_back(34'((1 << (r[1:0] + 1)) + 2));
    modTick <= 1'b1;
    chopPhaseStart <= 1'b1;
    @(posedge clk);
    chopPhaseStart <= 1'b0;
    repeat (2) @(posedge clk);
    chk("settling", 34'(chopSettling), 34'h1);
    repeat (40) @(posedge clk);
    rd(6'h30, 16'h0004);
    bus(1'b1, 6'h18, 16'h0600);
    chopPhaseStart <= 1'b1;
    @(posedge clk);
    chopPhaseStart <= 1'b0;
    repeat (3) @(posedge clk);
    chk("settling when off", 34'(chopSettling), 34'h0);
    rd(6'h3C, 16'h0000, 2'h3);
    chk("unanswered", 34'(q.size() + settleQ.size()), 34'h0);
    end_of_test();
  end
endmodule
